// ==== spi_port_pkg.sv ====
// Shared constants, register map and types for the serial port pair.
// Assumes a single 40 MHz system clock and byte-wide register access.
package spi_port_pkg;

  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [7:0] ADDR_DATA = 8'h11;
  localparam logic [7:0] ADDR_CTRL = 8'h12;
  localparam logic [7:0] ADDR_CSR  = 8'h13;

  localparam int CTRL_IRQ_EN   = 7;
  localparam int CTRL_PORT_EN  = 6;
  localparam int CTRL_HALF_OFF = 5;
  localparam int CTRL_MASTER   = 4;
  localparam int CTRL_IDLE_LVL = 3;
  localparam int CTRL_PHASE    = 2;
  localparam int CTRL_RATE_HI  = 1;
  localparam int CTRL_RATE_LO  = 0;
  localparam int CSR_OUT_DIS   = 2;
  localparam int CSR_SEL_SOFT  = 1;
  localparam int CSR_SEL_LVL   = 0;

  localparam logic [7:0] CTRL_RST_VAL = 8'h00;
  localparam logic [7:0] CSR_WR_MASK  = 8'h07;
  localparam logic [7:0] ZERO_BYTE    = 8'h00;

  // ----------------------------------------
  // Shift engine
  // ----------------------------------------
  localparam int         BYTE_W    = 8;
  localparam int         HALF_W    = 8;
  localparam logic [3:0] EDGE_LAST = 4'hF;
  localparam logic [3:0] EDGE_ZERO = 4'h0;

  // Clock-rate bases with the divide-by-2 stage in use; half_off halves them
  localparam logic [HALF_W-1:0] RATE_BASE_0 = 8'h04;
  localparam logic [HALF_W-1:0] RATE_BASE_1 = 8'h08;
  localparam logic [HALF_W-1:0] RATE_BASE_2 = 8'h20;
  localparam logic [HALF_W-1:0] RATE_BASE_3 = 8'h40;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_XFER = 2'b10
  } xfer_state_t;

  // System clocks per half serial-clock period
  function automatic logic [HALF_W-1:0] half_period(input logic half_off,
                                                    input logic [1:0] rate);
    logic [HALF_W-1:0] ratio;
    ratio = RATE_BASE_0;
    case (rate)
      2'b00: ratio = RATE_BASE_0;
      2'b01: ratio = RATE_BASE_1;
      2'b10: ratio = RATE_BASE_2;
      default: ratio = RATE_BASE_3;
    endcase
    half_period = half_off ? (ratio >> 1) : ratio;
  endfunction

endpackage

// ==== spi_link_if.sv ====
// Serial link between the port and the far controller.
// Resolves each shared wire from the drivers' enables; idle pulls assumed.
interface spi_link_if;
  logic dev_sck_o, dev_sck_oe, dev_mosi_o, dev_mosi_oe, dev_miso_o, dev_miso_oe;
  logic far_sck_o, far_sck_oe, far_mosi_o, far_mosi_oe, far_ss_n_o, far_ss_n_oe;
  logic sck, mosi, miso, ss_n;

  assign sck  = dev_sck_oe ? dev_sck_o : (far_sck_oe ? far_sck_o : 1'b0);
  assign mosi = dev_mosi_oe ? dev_mosi_o : (far_mosi_oe ? far_mosi_o : 1'b0);
  assign miso = dev_miso_oe ? dev_miso_o : 1'b0;
  // Select line pulled up while nobody drives it
  assign ss_n = far_ss_n_oe ? far_ss_n_o : 1'b1;

  modport device (
    input  sck, mosi, miso, ss_n,
    output dev_sck_o, dev_sck_oe, dev_mosi_o, dev_mosi_oe, dev_miso_o, dev_miso_oe
  );
  modport far (
    input  miso,
    output far_sck_o, far_sck_oe, far_mosi_o, far_mosi_oe, far_ss_n_o, far_ss_n_oe
  );
endinterface

// ==== spi_shift_core.sv ====
// Byte shift engine for master or slave operation, both clock phases.
// Assumes line inputs are synchronous to i_clk_sys.
module spi_shift_core
  import spi_port_pkg::*;
#(
  parameter int DIV_W = HALF_W
) (
  // Clock and reset
  input  wire logic              i_clk_sys,
  input  wire logic              i_rst,
  // Configuration
  input  wire logic              i_run,
  input  wire logic              i_abort,
  input  wire logic              i_master,
  input  wire logic              i_idle_level_bit,
  input  wire logic              i_sample_phase_bit,
  input  wire logic [DIV_W-1:0]  i_half,
  // Byte side
  input  wire logic              i_load,
  input  wire logic [BYTE_W-1:0] i_tx,
  output logic                   o_busy,
  output logic                   o_done,
  output logic [BYTE_W-1:0]      o_rx,
  // Line side
  input  wire logic              i_sck,
  input  wire logic              i_sel,
  input  wire logic              i_sdi,
  output logic                   o_sck,
  output logic                   o_sdo
);

  xfer_state_t       state;
  logic [3:0]        edge_cnt;
  logic [DIV_W-1:0]  div_cnt;
  logic [BYTE_W-1:0] shreg;
  logic [BYTE_W-1:0] next_shreg;
  logic              rbit;
  logic              sck_prev;
  logic              xfer, tick, slave_edge, edge_evt, cap, last, start;

  assign xfer       = (state == ST_XFER);
  assign tick       = i_master && xfer && (div_cnt == i_half - DIV_W'(1));
  assign slave_edge = !i_master && i_sel && (i_sck != sck_prev);
  assign edge_evt   = i_run && (tick || slave_edge);
  assign cap        = (edge_cnt[0] == i_sample_phase_bit);
  assign last       = (edge_cnt == EDGE_LAST);
  // Phase 0 slave is busy for the whole select window
  assign o_busy     = xfer || (!i_master && i_sel && !i_sample_phase_bit);
  assign start      = i_run && i_load && !o_busy;
  assign o_sdo      = shreg[BYTE_W-1];

  always_comb begin
    next_shreg = shreg;
    if (last && i_sample_phase_bit) begin
      next_shreg = {shreg[BYTE_W-2:0], i_sdi};
    end else if (!cap && !(i_sample_phase_bit && edge_cnt == EDGE_ZERO)) begin
      next_shreg = {shreg[BYTE_W-2:0], rbit};
    end
  end

  // ----------------------------------------
  // Sequencing
  // ----------------------------------------
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      state    <= ST_IDLE;
      edge_cnt <= EDGE_ZERO;
    end else begin
      case (state)
        ST_IDLE: begin
          if (i_abort) begin
            edge_cnt <= EDGE_ZERO;
          end else if (start && i_master) begin
            state    <= ST_XFER;
            edge_cnt <= EDGE_ZERO;
          end else if (edge_evt) begin
            edge_cnt <= edge_cnt + 4'h1;
            state    <= last ? ST_IDLE : ST_XFER;
          end else if (!i_master && !i_sel) begin
            edge_cnt <= EDGE_ZERO;
          end
        end
        ST_XFER: begin
          if (i_abort || (!i_master && !i_sel)) begin
            state    <= ST_IDLE;
            edge_cnt <= EDGE_ZERO;
          end else if (edge_evt) begin
            edge_cnt <= edge_cnt + 4'h1;
            state    <= last ? ST_IDLE : ST_XFER;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      div_cnt <= '0;
    end else if (!xfer || tick) begin
      div_cnt <= '0;
    end else if (i_run) begin
      div_cnt <= div_cnt + DIV_W'(1);
    end
  end

  // Idle level follows polarity only between bytes
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_sck <= 1'b0;
    end else if (!xfer) begin
      o_sck <= i_idle_level_bit;
    end else if (i_run && tick) begin
      o_sck <= !o_sck;
    end
  end

  // ----------------------------------------
  // Data path
  // ----------------------------------------
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      shreg    <= ZERO_BYTE;
      rbit     <= 1'b0;
      sck_prev <= 1'b0;
    end else begin
      sck_prev <= i_sck;
      if (start) begin
        shreg <= i_tx;
      end else if (edge_evt) begin
        // Unloaded shift register echoes the last byte received
        shreg <= next_shreg;
        if (cap) begin
          rbit <= i_sdi;
        end
      end
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_done <= 1'b0;
      o_rx   <= ZERO_BYTE;
    end else begin
      o_done <= edge_evt && last;
      if (edge_evt && last) begin
        o_rx <= next_shreg;
      end
    end
  end

endmodule

// ==== spi_port_device.sv ====
// Serial peripheral port with error flags, shared interrupt and halt wake.
// Assumes a processor port: one-cycle strobes, read data the cycle after.

module spi_port_device
  import spi_port_pkg::*;
(
  // Clock and reset
  input  wire logic              i_clk_sys,
  input  wire logic              i_rst,
  // Processor register port
  input  wire logic [7:0]        i_addr,
  input  wire logic [BYTE_W-1:0] i_wdata,
  input  wire logic              i_wr,
  input  wire logic              i_rd,
  output logic      [BYTE_W-1:0] o_rdata,
  // Processor state
  input  wire logic              i_int_mask,
  input  wire logic              i_wait,
  input  wire logic              i_halt,
  output logic                   o_irq,
  output logic                   o_wake,
  output logic                   o_halt_state,
  // Serial link
  spi_link_if.device             link
);

  logic [BYTE_W-1:0] ctrl;
  logic [BYTE_W-1:0] rx_buf;
  logic              done, write_collision_flag, overrun_flag, mode_fault_flag;
  logic              out_dis, sel_soft, sel_lvl;
  logic              csr_seen, mode_fault_flag_seen;
  logic              halt_q, halt_armed;
  logic              core_busy, core_done, core_sck, core_sdo;
  logic [BYTE_W-1:0] core_rx;
  logic              ss_eff, master, port_en, run, irq_cond, halt_entry, arm_ok;
  logic              csr_acc, csr_rd, data_acc, data_wr, ctrl_wr, load, mode_fault_flag_evt;

  assign master     = ctrl[CTRL_MASTER];
  assign port_en    = ctrl[CTRL_PORT_EN];
  assign ss_eff     = sel_soft ? sel_lvl : link.ss_n;
  assign csr_acc    = (i_rd || i_wr) && (i_addr == ADDR_CSR);
  assign csr_rd     = i_rd && (i_addr == ADDR_CSR);
  assign data_acc   = (i_rd || i_wr) && (i_addr == ADDR_DATA);
  assign data_wr    = i_wr && (i_addr == ADDR_DATA);
  assign ctrl_wr    = i_wr && (i_addr == ADDR_CTRL);
  assign mode_fault_flag_evt   = master && port_en && !ss_eff;
  // Writes also held off while done is set and control/status not yet read or written
  assign load       = data_wr && !core_busy && !(done && !csr_seen);
  assign halt_entry = i_halt && !halt_q;
  assign arm_ok     = !ss_eff && !master && port_en;
  // Halt freezes the port unless it was armed as a selected slave
  assign run        = port_en && (!i_halt || halt_armed);
  assign irq_cond   = (done || mode_fault_flag || overrun_flag) && ctrl[CTRL_IRQ_EN] && !i_int_mask;

  spi_shift_core #(
    .DIV_W (HALF_W)
  ) u_core (
    .i_clk_sys (i_clk_sys),
    .i_rst     (i_rst),
    .i_run     (run),
    .i_abort   (!port_en),
    .i_master  (master),
    .i_idle_level_bit    (ctrl[CTRL_IDLE_LVL]),
    .i_sample_phase_bit    (ctrl[CTRL_PHASE]),
    .i_half    (half_period(ctrl[CTRL_HALF_OFF], ctrl[CTRL_RATE_HI:CTRL_RATE_LO])),
    .i_load    (load),
    .i_tx      (i_wdata),
    .o_busy    (core_busy),
    .o_done    (core_done),
    .o_rx      (core_rx),
    .i_sck     (link.sck),
    .i_sel     (!ss_eff),
    .i_sdi     (master ? link.miso : link.mosi),
    .o_sck     (core_sck),
    .o_sdo     (core_sdo)
  );

  assign link.dev_sck_o  = core_sck;
  assign link.dev_mosi_o = core_sdo;
  assign link.dev_miso_o = core_sdo;

  // ----------------------------------------
  // Pin roles
  // ----------------------------------------
  // Registered enables: roles settle one cycle after a control change
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      link.dev_sck_oe  <= 1'b0;
      link.dev_mosi_oe <= 1'b0;
      link.dev_miso_oe <= 1'b0;
    end else begin
      link.dev_sck_oe  <= port_en && master;
      link.dev_mosi_oe <= port_en && master && !out_dis;
      link.dev_miso_oe <= port_en && !master && !ss_eff && !out_dis;
    end
  end

  // ----------------------------------------
  // Control register
  // ----------------------------------------
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      ctrl <= CTRL_RST_VAL;
    end else if (mode_fault_flag_evt) begin
      ctrl[CTRL_PORT_EN] <= 1'b0;
      ctrl[CTRL_MASTER]  <= 1'b0;
    end else if (ctrl_wr) begin
      ctrl <= i_wdata;
      if (mode_fault_flag && !mode_fault_flag_seen) begin
        ctrl[CTRL_PORT_EN] <= 1'b0;
        ctrl[CTRL_MASTER]  <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      out_dis  <= 1'b0;
      sel_soft <= 1'b0;
      sel_lvl  <= 1'b0;
    end else if (i_wr && i_addr == ADDR_CSR) begin
      out_dis  <= i_wdata[CSR_OUT_DIS] & CSR_WR_MASK[CSR_OUT_DIS];
      sel_soft <= i_wdata[CSR_SEL_SOFT] & CSR_WR_MASK[CSR_SEL_SOFT];
      sel_lvl  <= i_wdata[CSR_SEL_LVL] & CSR_WR_MASK[CSR_SEL_LVL];
    end
  end

  // ----------------------------------------
  // Status flags
  // ----------------------------------------
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      done <= 1'b0;
      overrun_flag  <= 1'b0;
    end else begin
      if (core_done) begin
        done <= 1'b1;
      end else if (data_acc && csr_seen) begin
        done <= 1'b0;
      end
      if (core_done && done) begin
        overrun_flag <= 1'b1;
      end else if (csr_rd) begin
        overrun_flag <= 1'b0;
      end
    end
  end

  // Buffer only takes the first byte after done was cleared
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      rx_buf <= ZERO_BYTE;
    end else if (core_done && !done) begin
      rx_buf <= core_rx;
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      write_collision_flag     <= 1'b0;
      csr_seen <= 1'b0;
    end else begin
      if (data_wr && core_busy) begin
        write_collision_flag <= 1'b1;
      end else if (data_acc && csr_seen) begin
        write_collision_flag <= 1'b0;
      end
      if (csr_acc) begin
        csr_seen <= 1'b1;
      end else if (data_acc) begin
        csr_seen <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      mode_fault_flag      <= 1'b0;
      mode_fault_flag_seen <= 1'b0;
    end else begin
      if (mode_fault_flag_evt) begin
        mode_fault_flag <= 1'b1;
      end else if (ctrl_wr && mode_fault_flag_seen) begin
        mode_fault_flag <= 1'b0;
      end
      if (csr_rd && mode_fault_flag) begin
        mode_fault_flag_seen <= 1'b1;
      end else if (ctrl_wr) begin
        mode_fault_flag_seen <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Interrupt and low power
  // ----------------------------------------
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_irq  <= 1'b0;
      o_wake <= 1'b0;
    end else begin
      // Collision flag deliberately left out of the request
      o_irq  <= irq_cond;
      o_wake <= (i_wait && irq_cond)
             || (i_halt && halt_armed && done && ctrl[CTRL_IRQ_EN] && !i_int_mask);
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      halt_q       <= 1'b0;
      halt_armed   <= 1'b0;
      o_halt_state <= 1'b0;
    end else begin
      halt_q <= i_halt;
      if (halt_entry) begin
        halt_armed <= arm_ok;
      end else if (!i_halt) begin
        halt_armed <= 1'b0;
      end
      if (halt_entry && arm_ok) begin
        o_halt_state <= 1'b1;
      end else if (master || !port_en) begin
        o_halt_state <= 1'b0;
      end else if (core_done && !i_halt) begin
        o_halt_state <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Read port
  // ----------------------------------------
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_rdata <= ZERO_BYTE;
    end else if (i_rd && i_addr == ADDR_DATA) begin
      o_rdata <= rx_buf;
    end else if (i_rd && i_addr == ADDR_CTRL) begin
      o_rdata <= ctrl;
    end else if (i_rd && i_addr == ADDR_CSR) begin
      o_rdata <= {done, write_collision_flag, overrun_flag, mode_fault_flag, 1'b0, out_dis, sel_soft, sel_lvl};
    end else begin
      o_rdata <= ZERO_BYTE;
    end
  end

endmodule

// ==== spi_far_master.sv ====
// Far controller acting as the single master of the link.
// Assumes one slave on the link; select is a plain output pin.
module spi_far_master
  import spi_port_pkg::*;
(
  // Clock and reset
  input  wire logic              i_clk_sys,
  input  wire logic              i_rst,
  // Configuration
  input  wire logic              i_select,
  input  wire logic              i_idle_level_bit,
  input  wire logic              i_sample_phase_bit,
  input  wire logic [HALF_W-1:0] i_half,
  // Byte side
  input  wire logic              i_start,
  input  wire logic [BYTE_W-1:0] i_tx,
  output logic                   o_busy,
  output logic                   o_done,
  output logic      [BYTE_W-1:0] o_rx,
  // Serial link
  spi_link_if.far                link
);

  logic              idle_level_bit, sample_phase_bit;
  logic [HALF_W-1:0] half;
  logic              core_busy;

  spi_shift_core #(
    .DIV_W (HALF_W)
  ) u_core (
    .i_clk_sys (i_clk_sys),
    .i_rst     (i_rst),
    .i_run     (1'b1),
    .i_abort   (1'b0),
    .i_master  (1'b1),
    .i_idle_level_bit    (idle_level_bit),
    .i_sample_phase_bit    (sample_phase_bit),
    .i_half    (half),
    .i_load    (i_start),
    .i_tx      (i_tx),
    .o_busy    (core_busy),
    .o_done    (o_done),
    .o_rx      (o_rx),
    .i_sck     (1'b0),
    .i_sel     (1'b0),
    .i_sdi     (link.miso),
    .o_sck     (link.far_sck_o),
    .o_sdo     (link.far_mosi_o)
  );

  // ----------------------------------------
  // Settings and pins
  // ----------------------------------------
  // Timing changes only while deselected and idle, never mid-byte
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      idle_level_bit <= 1'b0;
      sample_phase_bit <= 1'b0;
      half <= RATE_BASE_0;
    end else if (!core_busy && !i_select) begin
      idle_level_bit <= i_idle_level_bit;
      sample_phase_bit <= i_sample_phase_bit;
      half <= i_half;
    end
  end

  // Select held low as long as asked, also across a slave halt
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      link.far_ss_n_o  <= 1'b1;
      link.far_ss_n_oe <= 1'b0;
      link.far_sck_oe  <= 1'b0;
      link.far_mosi_oe <= 1'b0;
      o_busy           <= 1'b0;
    end else begin
      link.far_ss_n_o  <= !i_select;
      link.far_ss_n_oe <= 1'b1;
      link.far_sck_oe  <= 1'b1;
      link.far_mosi_oe <= 1'b1;
      o_busy           <= core_busy;
    end
  end

endmodule

// ==== spi_port_asserts.sv ====
// Link-wire checks for the port pair joined over one link.
// Assumes the far master owns clock and select; all wires resolved.
module spi_port_asserts (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst,
  // Link wires and enables
  input wire logic dev_sck_oe,
  input wire logic dev_mosi_oe,
  input wire logic dev_miso_oe,
  input wire logic sck,
  input wire logic mosi,
  input wire logic miso,
  input wire logic ss_n
);
  timeunit 1ns;
  timeprecision 100ps;

  // ----------------------------------------
  // Edge count within a selection
  // ----------------------------------------
  logic [3:0] edge_cnt;
  logic       sck_d;

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      edge_cnt <= 4'h0;
    end else if (ss_n) begin
      edge_cnt <= 4'h0;
    end else if (sck != sck_d) begin
      edge_cnt <= edge_cnt + 4'h1;
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      sck_d <= 1'h0;
    end else begin
      sck_d <= sck;
    end
  end

  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);

  no_sck_clash_a: assert property (!dev_sck_oe || !dev_mosi_oe || !dev_miso_oe)
    else $error("device drives clock, mosi and miso together");
  slave_no_mosi_a: assert property (!dev_sck_oe |-> !dev_mosi_oe)
    else $error("slave drives mosi");
  miso_quiet_a: assert property (ss_n && $past(ss_n) |-> !dev_miso_oe)
    else $error("miso driven while deselected");
  byte_edges_a: assert property ($changed(ss_n) |-> edge_cnt == 4'h0)
    else $error("select moved inside a byte");
  half_min_a: assert property (!ss_n && $changed(sck) |=> $stable(sck))
    else $error("serial clock half period below two cycles");
  miso_setup_a: assert property (!ss_n && $changed(sck) && dev_miso_oe |-> $stable(miso))
    else $error("miso moved on a clock edge");
  // Phase 0 only: even edges capture, odd edges shift mosi on purpose
  mosi_setup_a: assert property (!ss_n && $changed(sck) && !edge_cnt[0] |-> $stable(mosi))
    else $error("mosi moved on a capture edge");
  idle_hold_a: assert property ($fell(ss_n) |-> $stable(sck) [*2])
    else $error("clock left idle level at selection");

  cover property (edge_cnt == 4'hF && $changed(sck));
  cover property ($rose(ss_n));
  cover property (dev_miso_oe && $changed(miso));
endmodule

// ==== spi_error_lowpower_control_test.sv ====
// Self-checking bench: device slave and far master over one link.
// Assumes far master timing fixed at idle_level_bit 0, sample_phase_bit 0, fastest rate.
module spi_error_lowpower_control_test;
  import spi_port_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;

  // ----------------------------------------
  // Signals and instances
  // ----------------------------------------
  logic       i_clk_sys, i_rst, i_wr, i_rd, i_int_mask, i_wait, i_halt;
  logic       i_select, i_start, o_irq, o_wake, o_halt_state, o_busy, o_done;
  logic [7:0] i_addr, i_wdata, i_tx, o_rdata, o_rx;
  int         errors, checks;

  spi_link_if link ();
  spi_port_device i_spi_port_device (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_int_mask(i_int_mask),
    .i_wait(i_wait), .i_halt(i_halt), .o_irq(o_irq), .o_wake(o_wake),
    .o_halt_state(o_halt_state), .link(link));
  spi_far_master i_spi_far_master (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_select(i_select),
    .i_idle_level_bit(1'h0), .i_sample_phase_bit(1'h0), .i_half(8'h02), .i_start(i_start), .i_tx(i_tx),
    .o_busy(o_busy), .o_done(o_done), .o_rx(o_rx), .link(link));
  spi_port_asserts i_spi_port_asserts (.i_clk_sys(i_clk_sys), .i_rst(i_rst),
    .dev_sck_oe(link.dev_sck_oe), .dev_mosi_oe(link.dev_mosi_oe),
    .dev_miso_oe(link.dev_miso_oe), .sck(link.sck), .mosi(link.mosi), .miso(link.miso),
    .ss_n(link.ss_n));

  always #12.5 i_clk_sys = ~i_clk_sys;

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk_sys);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'h1;
    @(posedge i_clk_sys);
    i_wr <= 1'h0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge i_clk_sys);
    i_addr <= a;
    i_rd <= 1'h1;
    @(posedge i_clk_sys);
    i_rd <= 1'h0;
    #1;
    check($sformatf("register %h", a), o_rdata, exp);
  endtask

  // Far master byte; device flags land within the trailing wait
  task automatic xfer(input logic [7:0] tx, input logic [7:0] exp, input bit chk);
    int n;
    @(posedge i_clk_sys);
    i_tx <= tx;
    i_start <= 1'h1;
    @(posedge i_clk_sys);
    i_start <= 1'h0;
    n = 0;
    while (o_done !== 1'h1 && n < 200) begin
      @(posedge i_clk_sys);
      n++;
    end
    if (n == 200) errors++;
    check("far busy", o_busy, 8'h01);
    if (chk) check("far rx", o_rx, exp);
    repeat (4) @(posedge i_clk_sys);
  endtask

  // Far master takes new settings only while deselected, so settle first
  task automatic sel(input logic v);
    @(posedge i_clk_sys);
    i_select <= v;
    repeat (3) @(posedge i_clk_sys);
  endtask

  task automatic close_out();
    if (errors == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge i_clk_sys);
    errors++;
    close_out();
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    errors = 0;
    checks = 0;
    {i_clk_sys, i_wr, i_rd, i_int_mask, i_wait, i_halt, i_select, i_start} = 8'h00;
    {i_addr, i_wdata, i_tx} = 24'h000000;
    i_rst = 1'h1;
    repeat (4) @(posedge i_clk_sys);
    i_rst <= 1'h0;
    rd(ADDR_CTRL, CTRL_RST_VAL);
    rd(ADDR_CSR, 8'h00);
    rd(8'h20, 8'h00);
    wr(ADDR_CTRL, 8'hC0);
    wr(ADDR_DATA, 8'h5A);
    i_wait <= 1'h1;
    sel(1'h1);
    xfer(8'h3C, 8'h5A, 1'b1);
    check("irq", o_irq, 8'h01);
    check("wake", o_wake, 8'h01);
    i_wait <= 1'h0;
    rd(ADDR_CSR, 8'h80);
    rd(ADDR_DATA, 8'h3C);
    wr(ADDR_DATA, 8'h77);
    rd(ADDR_CSR, 8'h40);
    check("irq", o_irq, 8'h00);
    rd(ADDR_DATA, 8'h3C);
    xfer(8'hA5, 8'h3C, 1'b1);
    xfer(8'h96, 8'hA5, 1'b1);
    i_int_mask <= 1'h1;
    repeat (2) @(posedge i_clk_sys);
    check("masked irq", o_irq, 8'h00);
    i_int_mask <= 1'h0;
    rd(ADDR_CSR, 8'hA0);
    rd(ADDR_CSR, 8'h80);
    rd(ADDR_DATA, 8'hA5);
    // Halt entered while selected: armed; drive it on an edge
    @(posedge i_clk_sys);
    i_halt <= 1'h1;
    repeat (2) @(posedge i_clk_sys);
    check("halt state", o_halt_state, 8'h01);
    xfer(8'h11, 8'h96, 1'b1);
    check("wake", o_wake, 8'h01);
    i_halt <= 1'h0;
    rd(ADDR_CSR, 8'h80);
    rd(ADDR_DATA, 8'h11);
    xfer(8'h22, 8'h11, 1'b1);
    check("halt state", o_halt_state, 8'h00);
    rd(ADDR_CSR, 8'h80);
    rd(ADDR_DATA, 8'h22);
    // Halt entered while deselected: no wake possible
    sel(1'h0);
    i_halt <= 1'h1;
    sel(1'h1);
    xfer(8'h33, 8'h00, 1'b0);
    check("wake", o_wake, 8'h00);
    i_halt <= 1'h0;
    rd(ADDR_CSR, 8'h00);
    wr(ADDR_CTRL, 8'h80);
    xfer(8'h44, 8'h00, 1'b1);
    rd(ADDR_CSR, 8'h00);
    // Master select while the far end holds select low: mode fault
    wr(ADDR_CTRL, 8'hD0);
    rd(ADDR_CTRL, 8'h80);
    rd(ADDR_CSR, 8'h10);
    check("fault irq", o_irq, 8'h01);
    close_out();
  end
endmodule
